// file: verilog/autoneg_pkg.sv
package autoneg_pkg;

    // Register indices; byte address is four times the index
    localparam logic [5:0] REG_CTRL = 6'h00;
    localparam logic [5:0] REG_STAT = 6'h01;
    localparam logic [5:0] REG_ADV  = 6'h04;
    localparam logic [5:0] REG_LPA  = 6'h05;
    localparam logic [5:0] REG_EXP  = 6'h06;
    localparam logic [5:0] REG_CONS = 6'h11;
    localparam logic [5:0] REG_RFLT = 6'h13;

    // Control field positions
    localparam int CTRL_RESTART_BIT = 9;
    localparam int CTRL_ENABLE_BIT  = 12;
    // Status field positions
    localparam int STAT_RFAULT_BIT   = 4;
    localparam int STAT_COMPLETE_BIT = 5;
    // Ability word field positions
    localparam int TECH_LSB        = 5;
    localparam int TECH_W          = 5;
    localparam int ABIL_RFAULT_BIT = 13;
    // Expansion field positions
    localparam int EXP_LPCAP_BIT   = 0;
    localparam int EXP_PDFAULT_BIT = 4;
    // Consolidated status field positions
    localparam int CONS_RATE_BIT     = 15;
    localparam int CONS_DUPLEX_BIT   = 14;
    localparam int CONS_PROG_LSB     = 11;
    localparam int CONS_COMPLETE_BIT = 4;
    localparam int CONS_NOSIG_BIT    = 3;
    localparam int CONS_RFAULT_BIT   = 1;
    // Remote fault register field position
    localparam int RFLT_BIT = 13;

    // Technology field bit indices
    localparam int T_10HD  = 0;
    localparam int T_10FD  = 1;
    localparam int T_100HD = 2;
    localparam int T_100FD = 3;
    localparam int T_T4    = 4;

    // Reset values
    localparam logic [15:0] ADV_RESET   = 16'h01E1;
    localparam logic        ENABLE_RESET = 1'b1;
    localparam logic [4:0]  SELECTOR    = 5'h01;

    // Burst spacing and retries before parallel detection
    localparam int CLK_MHZ          = 100;
    localparam int BURST_GAP_US     = 16000;
    localparam int BURST_GAP_CYCLES = BURST_GAP_US * CLK_MHZ;
    localparam int PD_MIN_BURSTS    = 1;

    // Selected technology towards the transceiver modules
    typedef struct packed {
        logic en_100tx;
        logic en_10t;
        logic full_duplex;
    } tech_sel_type;

endpackage

// file: verilog/tech_resolver.sv
`timescale 1ns/10ps
`default_nettype none

module tech_resolver (
    input  wire logic [4:0]                 adv_tech,
    input  wire logic [4:0]                 lpa_tech,
    output autoneg_pkg::tech_sel_type       sel,
    output logic                            sel_valid
);

    logic [4:0] common;

    // Common abilities only
    assign common = adv_tech & lpa_tech;

    // Fixed priority walk, four-lane technology never chosen
    always_comb begin
        sel       = '0;
        sel_valid = 1'b1;
        if (common[autoneg_pkg::T_100FD]) begin
            sel.en_100tx    = 1'b1;
            sel.full_duplex = 1'b1;
        end else if (common[autoneg_pkg::T_100HD]) begin
            sel.en_100tx = 1'b1;
        end else if (common[autoneg_pkg::T_10FD]) begin
            sel.en_10t      = 1'b1;
            sel.full_duplex = 1'b1;
        end else if (common[autoneg_pkg::T_10HD]) begin
            sel.en_10t = 1'b1;
        end else begin
            sel_valid = 1'b0;
        end
    end

endmodule // tech_resolver

`default_nettype wire

// file: verilog/link_autoneg_arbiter.sv
`timescale 1ns/10ps
`default_nettype none

module link_autoneg_arbiter #(
    parameter int BURST_GAP = autoneg_pkg::BURST_GAP_CYCLES,
    parameter int PD_BURSTS = autoneg_pkg::PD_MIN_BURSTS
) (
    input  wire logic                  ref_clk,
    input  wire logic                  arst_n,
    input  wire logic [7:0]            address,
    input  wire logic                  read,
    input  wire logic                  write,
    input  wire logic [31:0]           writedata,
    output logic [31:0]                readdata,
    output logic                       waitrequest,
    input  wire logic                  rx_flp_valid,
    input  wire logic [15:0]           rx_flp_word,
    input  wire logic                  rx_nlp_seen,
    input  wire logic                  rx_idle_seen,
    input  wire logic                  rx_signal_present,
    input  wire logic                  link_fail,
    output logic                       tx_burst,
    output logic [15:0]                tx_word,
    output autoneg_pkg::tech_sel_type  tech_on
);

    typedef enum logic [2:0] {
        st_idle,
        st_ability,
        st_ack,
        st_complete,
        st_fault
    } state_type;

    state_type                 state_r;
    logic                      ack_r;
    logic [31:0]               readdata_r;
    logic                      an_en_r;
    logic [15:0]               adv_r;
    logic [15:0]               lpa_r;
    logic                      lp_cap_r;
    logic                      pd_fault_r;
    logic                      complete_r;
    logic                      nosig_r;
    logic                      rfault_r;
    logic [3:0]                prog_r;
    logic [31:0]               gap_r;
    logic [7:0]                bursts_r;
    logic                      tx_burst_r;
    logic [15:0]               tx_word_r;
    autoneg_pkg::tech_sel_type tech_r;
    autoneg_pkg::tech_sel_type res_sel;
    logic                      res_valid;
    logic [5:0]                idx;
    logic                      acc_wr;
    logic                      acc_rd;
    logic                      restart;
    logic                      en_wr_val;
    logic                      pd_go;
    logic [15:0]               pd_word;

    // Number of concurrent indications
    function automatic logic [1:0] count3(input logic a, input logic b,
                                          input logic c);
        count3 = {1'b0, a} + {1'b0, b} + {1'b0, c};
    endfunction

    // Progress code of an arbiter state
    function automatic logic [3:0] prog_code(input state_type s);
        case (s)
            st_idle:     prog_code = 4'h0;
            st_ability:  prog_code = 4'h1;
            st_ack:      prog_code = 4'h2;
            st_fault:    prog_code = 4'h8;
            st_complete: prog_code = 4'hF;
            default:     prog_code = 4'h0;
        endcase
    endfunction

    tech_resolver u_res (
        .adv_tech  (adv_r[autoneg_pkg::TECH_LSB +: autoneg_pkg::TECH_W]),
        .lpa_tech  (lpa_r[autoneg_pkg::TECH_LSB +: autoneg_pkg::TECH_W]),
        .sel       (res_sel),
        .sel_valid (res_valid)
    );

    // Bus decode, one wait cycle per access
    assign idx         = address[7:2];
    assign waitrequest = (read | write) & ~ack_r;
    assign acc_wr      = write & ack_r;
    assign acc_rd      = read & ack_r;
    assign readdata    = readdata_r;
    assign en_wr_val   = writedata[autoneg_pkg::CTRL_ENABLE_BIT];

    // Restart sources
    always_comb begin
        restart = 1'b0;
        if (acc_wr && idx == autoneg_pkg::REG_CTRL) begin
            if (writedata[autoneg_pkg::CTRL_RESTART_BIT]) begin
                restart = 1'b1;
            end else if (en_wr_val && !an_en_r) begin
                restart = 1'b1;
            end
        end
        if (link_fail && state_r == st_complete) begin
            restart = 1'b1;
        end
    end

    // Parallel detection word and trigger
    always_comb begin
        pd_word = {11'h000, autoneg_pkg::SELECTOR};
        if (rx_idle_seen) begin
            pd_word[autoneg_pkg::TECH_LSB + autoneg_pkg::T_100HD] = 1'b1;
        end else begin
            pd_word[autoneg_pkg::TECH_LSB + autoneg_pkg::T_10HD] = 1'b1;
        end
        pd_go = (bursts_r >= PD_BURSTS[7:0]) && !rx_flp_valid;
    end

    // Access acknowledge
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= (read | write) & ~ack_r;
        end
    end

    // Read data captured before side effects of the read
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            readdata_r <= 32'h0000_0000;
        end else if (read && !ack_r) begin
            readdata_r <= 32'h0000_0000;
            if (idx == autoneg_pkg::REG_CTRL) begin
                readdata_r[autoneg_pkg::CTRL_ENABLE_BIT] <= an_en_r;
            end else if (idx == autoneg_pkg::REG_STAT) begin
                readdata_r[autoneg_pkg::STAT_COMPLETE_BIT] <= complete_r;
                readdata_r[autoneg_pkg::STAT_RFAULT_BIT] <= rfault_r;
            end else if (idx == autoneg_pkg::REG_ADV) begin
                readdata_r[15:0] <= adv_r;
            end else if (idx == autoneg_pkg::REG_LPA) begin
                readdata_r[15:0] <= lpa_r;
            end else if (idx == autoneg_pkg::REG_EXP) begin
                readdata_r[autoneg_pkg::EXP_LPCAP_BIT] <= lp_cap_r;
                readdata_r[autoneg_pkg::EXP_PDFAULT_BIT] <= pd_fault_r;
            end else if (idx == autoneg_pkg::REG_CONS) begin
                readdata_r[autoneg_pkg::CONS_RATE_BIT] <= tech_r.en_100tx;
                readdata_r[autoneg_pkg::CONS_DUPLEX_BIT] <=
                    tech_r.full_duplex;
                readdata_r[autoneg_pkg::CONS_PROG_LSB +: 3] <= prog_r[2:0];
                readdata_r[autoneg_pkg::CONS_COMPLETE_BIT] <=
                    prog_r[3] | complete_r;
                readdata_r[autoneg_pkg::CONS_NOSIG_BIT] <= nosig_r;
                readdata_r[autoneg_pkg::CONS_RFAULT_BIT] <= rfault_r;
            end else if (idx == autoneg_pkg::REG_RFLT) begin
                readdata_r[autoneg_pkg::RFLT_BIT] <= rfault_r;
            end
        end
    end

    // Enable and advertisement registers
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            an_en_r <= autoneg_pkg::ENABLE_RESET;
            adv_r   <= autoneg_pkg::ADV_RESET;
        end else if (acc_wr) begin
            if (idx == autoneg_pkg::REG_CTRL) begin
                an_en_r <= en_wr_val;
            end else if (idx == autoneg_pkg::REG_ADV) begin
                adv_r <= writedata[15:0];
            end
        end
    end

    // Arbitration state machine
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r <= st_idle;
        end else if (!an_en_r) begin
            state_r <= st_idle;
        end else if (restart) begin
            state_r <= st_ability;
        end else begin
            case (state_r)
                st_idle: begin
                    state_r <= st_ability;
                end
                st_ability: begin
                    if (count3(rx_flp_valid, rx_nlp_seen, rx_idle_seen)
                        > 2'd1) begin
                        state_r <= st_fault;
                    end else if (rx_flp_valid) begin
                        state_r <= st_ack;
                    end else if (pd_go && (rx_nlp_seen || rx_idle_seen)) begin
                        state_r <= st_complete;
                    end
                end
                st_ack: begin
                    if (res_valid) begin
                        state_r <= st_complete;
                    end else begin
                        state_r <= st_fault;
                    end
                end
                st_complete: begin
                    state_r <= st_complete;
                end
                st_fault: begin
                    state_r <= st_fault;
                end
                default: begin
                    state_r <= st_idle;
                end
            endcase
        end
    end

    // Burst pacing while in ability detection
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            gap_r      <= 32'h0000_0000;
            bursts_r   <= 8'h00;
            tx_burst_r <= 1'b0;
            tx_word_r  <= 16'h0000;
        end else begin
            tx_burst_r <= 1'b0;
            if (!an_en_r || state_r != st_ability || restart) begin
                gap_r    <= 32'h0000_0000;
                bursts_r <= 8'h00;
            end else if (gap_r == 32'h0000_0000) begin
                gap_r      <= BURST_GAP[31:0] - 32'h0000_0001;
                tx_burst_r <= 1'b1;
                tx_word_r  <= adv_r;
                if (bursts_r != 8'hFF) begin
                    bursts_r <= bursts_r + 8'h01;
                end
            end else begin
                gap_r <= gap_r - 32'h0000_0001;
            end
        end
    end

    // Partner ability and expansion bits
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            lpa_r      <= 16'h0000;
            lp_cap_r   <= 1'b0;
            pd_fault_r <= 1'b0;
        end else if (an_en_r && state_r == st_ability && !restart) begin
            if (count3(rx_flp_valid, rx_nlp_seen, rx_idle_seen) > 2'd1) begin
                pd_fault_r <= 1'b1;
            end else if (rx_flp_valid) begin
                lpa_r    <= rx_flp_word;
                lp_cap_r <= 1'b1;
            end else if (pd_go && rx_nlp_seen) begin
                lpa_r    <= pd_word;
                lp_cap_r <= 1'b0;
            end else if (pd_go && rx_idle_seen) begin
                lpa_r    <= pd_word;
                lp_cap_r <= 1'b0;
            end
        end else if (an_en_r && restart) begin
            pd_fault_r <= 1'b0;
        end
    end

    // Completion flag and selected technology
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            complete_r <= 1'b0;
            tech_r     <= '0;
        end else if (!an_en_r) begin
            complete_r <= complete_r;
        end else if (restart) begin
            complete_r <= 1'b0;
            tech_r     <= '0;
        end else if (state_r == st_ack && res_valid) begin
            complete_r <= 1'b1;
            tech_r     <= res_sel;
        end else if (state_r == st_ability && pd_go &&
                     count3(rx_flp_valid, rx_nlp_seen, rx_idle_seen)
                     == 2'd1) begin
            complete_r         <= 1'b1;
            tech_r.en_100tx    <= rx_idle_seen;
            tech_r.en_10t      <= rx_nlp_seen;
            tech_r.full_duplex <= 1'b0;
        end else if (state_r == st_fault) begin
            tech_r <= '0;
        end
    end

    // Signal absence and remote fault
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            nosig_r  <= 1'b0;
            rfault_r <= 1'b0;
        end else begin
            nosig_r <= ~rx_signal_present;
            if (an_en_r && rx_flp_valid &&
                rx_flp_word[autoneg_pkg::ABIL_RFAULT_BIT]) begin
                rfault_r <= 1'b1;
            end else if (restart) begin
                rfault_r <= 1'b0;
            end
        end
    end

    // Progress monitor: latch higher codes, read latches present
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            prog_r <= 4'h0;
        end else if (acc_rd && idx == autoneg_pkg::REG_CONS) begin
            prog_r <= prog_code(state_r);
        end else if (prog_code(state_r) > prog_r) begin
            prog_r <= prog_code(state_r);
        end
    end

    // Registered outputs
    assign tx_burst = tx_burst_r;
    assign tx_word  = tx_word_r;
    assign tech_on  = tech_r;

endmodule // link_autoneg_arbiter

`default_nettype wire

// file: testbench/link_autoneg_arbiter_chk.sv
`timescale 1ns/10ps
`default_nettype none

module link_autoneg_arbiter_chk #(
    parameter int BURST_GAP = 20,
    parameter int PD_BURSTS = 1
) (
    input wire logic        ref_clk,
    input wire logic        arst_n,
    input wire logic [7:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    input wire logic        rx_signal_present,
    input wire logic        link_fail,
    input wire logic        tx_burst,
    input wire logic [15:0] tx_word,
    input wire logic [2:0]  tech_on
);
    logic        rdone;
    logic        wdone;
    logic [5:0]  idx;
    logic [15:0] adv_r;
    logic        en_r;
    logic [1:0]  off_cnt_r;
    logic        sig_prev_r;
    logic [1:0]  sig_cnt_r;

    // Completed bus transfers
    assign rdone = read && !waitrequest;
    assign wdone = write && !waitrequest;
    assign idx   = address[7:2];

    // Shadows of advertisement word and enable bit
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            adv_r <= autoneg_pkg::ADV_RESET;
            en_r  <= autoneg_pkg::ENABLE_RESET;
        end else if (wdone && idx == autoneg_pkg::REG_ADV) begin
            adv_r <= writedata[15:0];
        end else if (wdone && idx == autoneg_pkg::REG_CTRL) begin
            en_r <= writedata[autoneg_pkg::CTRL_ENABLE_BIT];
        end
    end

    // Saturating ages of disable and of receive energy level
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            off_cnt_r  <= 2'h0;
            sig_prev_r <= 1'b0;
            sig_cnt_r  <= 2'h0;
        end else begin
            off_cnt_r  <= en_r ? 2'h0 : off_cnt_r + {1'b0, off_cnt_r != 2'h3};
            sig_prev_r <= rx_signal_present;
            sig_cnt_r  <= (rx_signal_present != sig_prev_r) ? 2'h0 :
                          sig_cnt_r + {1'b0, sig_cnt_r != 2'h3};
        end
    end

    default clocking dcb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    burst_word_a: assert property (
        tx_burst |-> tx_word == adv_r || tx_word == $past(adv_r))
        else $error("burst word is not the advertisement");
    tech_single_a: assert property (
        tech_on != 3'h0 |-> tech_on[2] ^ tech_on[1])
        else $error("not exactly one technology enabled");
    restart_burst_a: assert property (
        wdone && idx == autoneg_pkg::REG_CTRL && writedata[9] && writedata[12]
        |-> ##[1:4] tx_burst)
        else $error("no burst after restart");
    self_clear_a: assert property (
        rdone && idx == autoneg_pkg::REG_CTRL |-> !readdata[9])
        else $error("restart bit reads one");
    reenable_burst_a: assert property (
        $rose(en_r) |-> ##[0:4] tx_burst)
        else $error("no burst after enable toggle");
    fail_drop_a: assert property (
        link_fail && tech_on != 3'h0 |=> tech_on == 3'h0)
        else $error("technology kept after link failure");
    quiet_off_a: assert property (
        off_cnt_r >= 2'h2 |-> !tx_burst)
        else $error("burst while disabled");
    done_tech_a: assert property (
        rdone && idx == autoneg_pkg::REG_STAT && readdata[5]
        |-> tech_on != 3'h0)
        else $error("complete without a technology");
    pd_fault_a: assert property (
        rdone && idx == autoneg_pkg::REG_EXP && readdata[4] |-> tech_on == 3'h0)
        else $error("technology enabled with detection fault");
    no_signal_a: assert property (
        rdone && idx == autoneg_pkg::REG_CONS && sig_cnt_r == 2'h3
        |-> readdata[3] == !rx_signal_present)
        else $error("signal absent bit wrong");

    // Main scenarios reached
    cover property (tech_on[2] && tech_on[0]);
    cover property (tech_on[1] && !tech_on[0]);
    cover property (rdone && idx == autoneg_pkg::REG_EXP && readdata[4]);
    cover property ($rose(en_r));
endmodule // link_autoneg_arbiter_chk

bind link_autoneg_arbiter link_autoneg_arbiter_chk #(
    .BURST_GAP(BURST_GAP), .PD_BURSTS(PD_BURSTS)) chk_inst (
    .ref_clk(ref_clk), .arst_n(arst_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .rx_signal_present(rx_signal_present),
    .link_fail(link_fail), .tx_burst(tx_burst), .tx_word(tx_word),
    .tech_on(tech_on));

`default_nettype wire

// file: testbench/remote_partner.sv
`timescale 1ns/10ps
`default_nettype none

module remote_partner (
    input  wire logic        ref_clk,
    input  wire logic        arst_n,
    input  wire logic [2:0]  mode,
    input  wire logic [3:0]  lag,
    input  wire logic [15:0] word,
    input  wire logic        tx_burst,
    output logic             rx_flp_valid,
    output logic [15:0]      rx_flp_word,
    output logic             rx_nlp_seen,
    output logic             rx_idle_seen,
    output logic             rx_signal_present
);
    logic [3:0] cnt_r;
    logic       heard_r;
    logic [2:0] mode_r;

    // Answer each burst after lag cycles; mode 1 negotiates
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_r        <= 4'h0;
            heard_r      <= 1'b0;
            mode_r       <= 3'h0;
            rx_flp_valid <= 1'b0;
            rx_flp_word  <= 16'h0;
        end else begin
            mode_r       <= mode;
            rx_flp_valid <= 1'b0;
            rx_flp_word  <= ~rx_flp_word; // Undriven word keeps changing
            cnt_r        <= tx_burst ? lag : cnt_r - {3'h0, cnt_r != 4'h0};
            heard_r      <= (mode == mode_r) && (heard_r || cnt_r == 4'h1);
            if (cnt_r == 4'h1 && mode == 3'h1) begin
                rx_flp_valid <= 1'b1;
                rx_flp_word  <= word;
            end
        end
    end

    // Legacy partners: 2 pulses, 3 idles, 4 both; 0 is silent
    assign rx_nlp_seen = heard_r && (mode == 3'h2 || mode == 3'h4);
    assign rx_idle_seen = heard_r && mode >= 3'h3;
    assign rx_signal_present = mode != 3'h0;
endmodule // remote_partner

`default_nettype wire

// file: testbench/link_autoneg_arbiter_tb.sv
`timescale 1ns/10ps
`default_nettype none

module link_autoneg_arbiter_tb;
    logic        ref_clk = 1'b0;
    logic        arst_n = 1'b0;
    logic [7:0]  address = 8'h00;
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic        waitrequest;
    logic        flp_v;
    logic [15:0] flp_w;
    logic        nlp;
    logic        idle;
    logic        sig;
    logic        link_fail = 1'b0;
    logic        tx_burst;
    logic [15:0] tx_word;
    logic [2:0]  tech_on;
    logic [2:0]  mode = 3'h0;
    logic [3:0]  lag = 4'h3;
    logic [15:0] word = 16'h0;
    logic [15:0] adv_sh = autoneg_pkg::ADV_RESET;
    logic [15:0] adv_old = autoneg_pkg::ADV_RESET;
    logic [31:0] exp_q[$];
    logic [31:0] msk_q[$];
    logic [31:0] m;
    logic [4:0]  ta[6] = '{5'h0F, 5'h07, 5'h03, 5'h11, 5'h02, 5'h0};
    logic [4:0]  tb[6] = '{5'h0F, 5'h0C, 5'h07, 5'h11, 5'h01, 5'h0};
    logic [4:0]  a;
    logic [4:0]  b;
    logic [2:0]  t;
    logic        rf;
    logic [15:0] w;
    int          failures = 0;
    int          n_checks = 0;
    int          cycles = 0;
    int          bursts = 0;
    int          n;
    int          seed = 53;

    always #5 ref_clk = ~ref_clk;

    link_autoneg_arbiter #(.BURST_GAP(20), .PD_BURSTS(1))
        link_autoneg_arbiter_inst (
        .ref_clk(ref_clk), .arst_n(arst_n), .address(address), .read(read),
        .write(write), .writedata(writedata), .readdata(readdata),
        .waitrequest(waitrequest), .rx_flp_valid(flp_v), .rx_flp_word(flp_w),
        .rx_nlp_seen(nlp), .rx_idle_seen(idle), .rx_signal_present(sig),
        .link_fail(link_fail), .tx_burst(tx_burst), .tx_word(tx_word),
        .tech_on(tech_on));

    remote_partner remote_partner_inst (
        .ref_clk(ref_clk), .arst_n(arst_n), .mode(mode), .lag(lag),
        .word(word), .tx_burst(tx_burst), .rx_flp_valid(flp_v),
        .rx_flp_word(flp_w), .rx_nlp_seen(nlp), .rx_idle_seen(idle),
        .rx_signal_present(sig));

    task automatic check(input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic report_and_stop();
        $display("checks=%0d failures=%0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // One transfer, held until waitrequest low
    task automatic bus(input logic wr, logic [5:0] idx, logic [31:0] d);
        @(posedge ref_clk);
        address   <= {idx, 2'b00};
        read      <= !wr;
        write     <= wr;
        writedata <= d;
        @(posedge ref_clk);
        while (waitrequest) @(posedge ref_clk);
        if (wr && idx == autoneg_pkg::REG_ADV) begin
            adv_old = adv_sh;
            adv_sh  = d[15:0];
        end
        read  <= 1'b0;
        write <= 1'b0;
    endtask

    task automatic rd(input logic [5:0] idx, logic [31:0] mk, e);
        msk_q.push_back(mk);
        exp_q.push_back(e);
        bus(1'b0, idx, 32'h0);
    endtask

    task automatic restart();
        bus(1'b1, autoneg_pkg::REG_CTRL, 32'h1200);
        repeat (30) @(posedge ref_clk);
    endtask

    function automatic logic [2:0] best(input logic [4:0] x, y);
        logic [4:0] c;
        c = x & y;
        if (c[autoneg_pkg::T_100FD]) return 3'b101;
        if (c[autoneg_pkg::T_100HD]) return 3'b100;
        if (c[autoneg_pkg::T_10FD]) return 3'b011;
        if (c[autoneg_pkg::T_10HD]) return 3'b010;
        return 3'b000;
    endfunction

    // Read results against notes, burst words, hang limit
    always @(posedge ref_clk) begin
        cycles++;
        if (read && !waitrequest && exp_q.size() > 0) begin
            m = msk_q.pop_front();
            check(readdata & m, exp_q.pop_front() & m);
        end
        if (tx_burst) begin
            bursts++;
            check({31'h0, tx_word === adv_sh || tx_word === adv_old}, 32'h1);
        end
        if (cycles == 20000) begin
            failures++;
            report_and_stop();
        end
    end

    // Main sequence
    initial begin
        repeat (12) @(posedge ref_clk);
        arst_n <= 1'b1;
        rd(autoneg_pkg::REG_CTRL, 32'h1200, 32'h1000);
        rd(autoneg_pkg::REG_ADV, 32'hFFFFFFFF, 32'h01E1);
        rd(6'h02, 32'hFFFFFFFF, 32'h0);
        for (int i = 0; i < 6; i++) begin
            a = (i == 5) ? 5'($random(seed)) : ta[i];
            b = (i == 5) ? 5'($random(seed)) : tb[i];
            rf = i[0];
            t = best(a, b);
            w = {2'b00, rf, 3'b000, b, 5'h01};
            word <= w;
            lag <= 4'h1 + 4'($random(seed) & 7);
            mode <= 3'h1;
            bus(1'b1, autoneg_pkg::REG_ADV, {16'h0, 6'h00, a, autoneg_pkg::SELECTOR});
            restart();
            check(32'(tech_on), 32'(t));
            rd(autoneg_pkg::REG_STAT, 32'h30, {26'h0, |t, rf, 4'h0});
            rd(autoneg_pkg::REG_LPA, 32'hFFFF, {16'h0, w});
            rd(autoneg_pkg::REG_EXP, 32'h11, 32'h01);
            rd(autoneg_pkg::REG_RFLT, 32'h2000, {18'h0, rf, 13'h0});
            rd(autoneg_pkg::REG_CONS, 32'hC002 | {27'h0, |t, 4'h0},
               {16'h0, t[2], t[0], 9'h0, |t, 2'b00, rf, 1'b0});
        end
        rd(autoneg_pkg::REG_CTRL, 32'h0200, 32'h0);
        bus(1'b1, autoneg_pkg::REG_ADV, 32'h01E1);
        for (int k = 2; k < 5; k++) begin
            mode <= 3'(k);
            restart();
            t = (k == 2) ? 3'b010 : (k == 3) ? 3'b100 : 3'b000;
            check(32'(tech_on), 32'(t));
            rd(autoneg_pkg::REG_STAT, 32'h20, {26'h0, |t, 5'h0});
            rd(autoneg_pkg::REG_EXP, 32'h11, {27'h0, k == 4, 4'h0});
            rd(autoneg_pkg::REG_LPA, (k == 4) ? 32'h0 : 32'hFFFF,
               (k == 2) ? 32'h21 : 32'h81);
        end
        mode <= 3'h0;
        restart();
        rd(autoneg_pkg::REG_CONS, 32'h08, 32'h08);
        rd(autoneg_pkg::REG_STAT, 32'h20, 32'h0);
        bus(1'b1, autoneg_pkg::REG_CTRL, 32'h0);
        word <= 16'h01E1;
        mode <= 3'h1;
        repeat (2) @(posedge ref_clk);
        n = bursts;
        repeat (60) @(posedge ref_clk);
        check(bursts - n, 0);
        bus(1'b1, autoneg_pkg::REG_CTRL, 32'h1000);
        repeat (30) @(posedge ref_clk);
        check({29'h0, tech_on}, 32'h5);
        link_fail <= 1'b1;
        @(posedge ref_clk);
        link_fail <= 1'b0;
        #1;
        check({29'h0, tech_on}, 32'h0);
        repeat (30) @(posedge ref_clk);
        check({29'h0, tech_on}, 32'h5);
        mode <= 3'h0;
        arst_n <= 1'b0;
        @(posedge ref_clk);
        #1;
        check({13'h0, tx_word, tech_on}, 32'h0);
        adv_sh = autoneg_pkg::ADV_RESET;
        adv_old = autoneg_pkg::ADV_RESET;
        repeat (3) @(posedge ref_clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge ref_clk);
        rd(autoneg_pkg::REG_STAT, 32'h20, 32'h0);
        rd(autoneg_pkg::REG_CONS, 32'h3818, 32'h0808);
        report_and_stop();
    end
endmodule // link_autoneg_arbiter_tb

`default_nettype wire
